// file: logic/cbw_regs.svh
// Register offsets, field positions, reset values and timing counts for the bus/core block
// =====================================================================
`ifndef CBW_REGS_SVH
`define CBW_REGS_SVH

// =====================================================================
// Register byte offsets
`define CBW_OFS_SYS_CONFIG_0 8'h00
`define CBW_OFS_SYS_CONFIG_1 8'h04
`define CBW_OFS_FLAG_WORD 8'h08
`define CBW_OFS_STACK_POINTER 8'h0C
`define CBW_OFS_INSTR_POINTER 8'h10
`define CBW_OFS_CORE_STATUS 8'h14

// =====================================================================
// Field positions
`define CBW_BIT_HIGH_FRAME_STRETCH 0
`define CBW_BIT_AUTO_STALL_OFF 0
`define CBW_BIT_CARRY 7
`define CBW_BIT_NEGATIVE 6
`define CBW_BIT_ZERO 5
`define CBW_BIT_OVERFLOW 4
`define CBW_BIT_LEVEL2_IRQ_GATE 3
`define CBW_BIT_LEVEL1_IRQ_GATE 2
`define CBW_FLAG_WORD_MASK 8'hFC

// =====================================================================
// Reset values
`define CBW_RST_FLAG_WORD 8'h00
`define CBW_RST_STACK_POINTER 8'h00
`define CBW_RST_CONFIG 1'b0

// =====================================================================
// Address map
`define CBW_VEC_HI_ADDR 16'h7FFE
`define CBW_VEC_LO_ADDR 16'h7FFF
`define CBW_PF_PAGE 8'h10
`define CBW_RAM_PAGE 8'h00
`define CBW_PF_HIGH_FRAME 4'hC
`define CBW_PF_ONCHIP_FIRST 4'h1
`define CBW_PF_ONCHIP_LAST 4'h7

// =====================================================================
// Access lengths in system clocks
`define CBW_CYC_BASE 3'h2
`define CBW_CYC_EXT_AUTO 3'h3
`define CBW_CYC_PF_STRETCH 3'h4

`endif

// file: logic/cbw_pkg.sv
// Types shared by the bus/core block
package cbw_pkg;

  // =====================================================================
  // Core sequencing states
  typedef enum logic [2:0] {
    CBW_BOOT_HI = 3'b001,
    CBW_BOOT_LO = 3'b010,
    CBW_RUN = 3'b100
  } cbw_core_state_t;

  // =====================================================================
  // Access timing states
  typedef enum logic [1:0] {
    CBW_ACC_IDLE = 2'b01,
    CBW_ACC_BUSY = 2'b10
  } cbw_acc_state_t;

endpackage

// file: logic/cbw_acc_if.sv
// Access request, decode and timing signals between the core and its helpers
`timescale 1ns/10ps
interface cbw_acc_if;
  logic req;
  logic [15:0] addr;
  logic is_ram;
  logic is_pf;
  logic is_ext;
  logic pf_high;
  logic pf_onchip;
  logic [3:0] pf_frame;
  logic busy;
  logic fin;

  modport core (output req, output addr, input is_ram, input is_pf, input is_ext,
    input pf_high, input pf_onchip, input pf_frame, input busy, input fin);
  modport dec (input addr, output is_ram, output is_pf, output is_ext, output pf_high,
    output pf_onchip, output pf_frame);
  modport timer (input req, input is_ext, input pf_high, output busy, output fin);
endinterface

// file: logic/cbw_addr_dec.sv
// Address decoder for the shared 16-bit map
`timescale 1ns/10ps
`include "cbw_regs.svh"
module cbw_addr_dec (
  cbw_acc_if.dec acc
);
  // =====================================================================
  // Region decode; everything outside RAM and the peripheral file goes off-chip
  wire ram_hit = (acc.addr[15:8] == `CBW_RAM_PAGE);
  wire pf_hit = (acc.addr[15:8] == `CBW_PF_PAGE);
  wire [3:0] frame = acc.addr[7:4];

  assign acc.is_ram = ram_hit;
  assign acc.is_pf = pf_hit;
  assign acc.pf_frame = frame;
  // Top four frames belong to outside peripherals
  assign acc.pf_high = pf_hit && (frame >= `CBW_PF_HIGH_FRAME);
  assign acc.pf_onchip = pf_hit && (frame >= `CBW_PF_ONCHIP_FIRST)
    && (frame <= `CBW_PF_ONCHIP_LAST);
  assign acc.is_ext = !ram_hit && (!pf_hit || acc.pf_high);
endmodule

// file: logic/cbw_wait_ctl.sv
// Wait-state generator that times each memory or peripheral access
`timescale 1ns/10ps
`include "cbw_regs.svh"
module cbw_wait_ctl (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic ext_stretch_n_in,
  input wire logic auto_stall_off_in,
  input wire logic high_frame_stretch_in,
  cbw_acc_if.timer acc
);
  cbw_pkg::cbw_acc_state_t state_r;
  cbw_pkg::cbw_acc_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] len;
  logic last;

  // =====================================================================
  // Total length; the frame stretch overrides the external setting
  always_comb begin
    if (acc.pf_high && high_frame_stretch_in) begin
      len = `CBW_CYC_PF_STRETCH;
    end else if (acc.is_ext && !auto_stall_off_in) begin
      len = `CBW_CYC_EXT_AUTO;
    end else begin
      len = `CBW_CYC_BASE;
    end
  end

  // Extend only counts once the programmed waits are spent, so an extend held from the start overlaps them rather than adding
  assign last = (state_r == cbw_pkg::CBW_ACC_BUSY) && (cnt_r == 3'h0)
    && !(acc.is_ext && !ext_stretch_n_in);
  assign acc.fin = last;
  assign acc.busy = (state_r == cbw_pkg::CBW_ACC_BUSY);

  // Next state and countdown
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      cbw_pkg::CBW_ACC_IDLE: begin
        if (acc.req) begin
          state_nxt = cbw_pkg::CBW_ACC_BUSY;
          cnt_nxt = len - 3'h2;
        end
      end
      cbw_pkg::CBW_ACC_BUSY: begin
        if (cnt_r != 3'h0) begin
          cnt_nxt = cnt_r - 3'h1;
        end else if (last) begin
          state_nxt = cbw_pkg::CBW_ACC_IDLE;
        end
      end
      default: begin
        state_nxt = cbw_pkg::CBW_ACC_IDLE;
        cnt_nxt = 3'h0;
      end
    endcase
  end

  // State flops
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= cbw_pkg::CBW_ACC_IDLE;
      cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// file: logic/cbw_core.sv
// Core registers, reset-vector fetch, access sequencing and AHB-Lite register slave
`timescale 1ns/10ps
`include "cbw_regs.svh"
module cbw_core (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // AHB-Lite register slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Instruction-side access requests
  input wire logic cpu_req_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic cpu_write_in,
  input wire logic [7:0] cpu_wdata_in,
  output logic cpu_ready_out,
  output logic [7:0] cpu_rdata_out,
  output logic cpu_stall_out,
  // Memory / peripheral access port
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  output logic mem_write_out,
  output logic mem_strobe_out,
  output logic ram_sel_out,
  output logic pf_sel_out,
  output logic pf_onchip_out,
  output logic [3:0] pf_frame_out,
  output logic ext_sel_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic ext_stretch_n_in,
  // Stack, flags, instruction pointer and interrupt gating
  input wire logic stk_push_in,
  input wire logic stk_pop_in,
  output logic [15:0] stk_addr_out,
  input wire logic flag_update_in,
  input wire logic [3:0] alu_flags_in,
  input wire logic [2:0] cond_sel_in,
  output logic cond_true_out,
  input wire logic ip_load_in,
  input wire logic [15:0] ip_value_in,
  input wire logic ip_step_in,
  output logic [15:0] instr_pointer_out,
  input wire logic irq_level1_in,
  input wire logic irq_level2_in,
  output logic irq_level1_take_out,
  output logic irq_level2_take_out
);
  cbw_acc_if acc ();

  // =====================================================================
  // Helpers
  cbw_addr_dec u_dec (
    .acc (acc)
  );

  logic auto_stall_off_r;
  logic high_frame_stretch_r;

  cbw_wait_ctl u_wait (
    .sys_clk_in (sys_clk_in),
    .rst_in (rst_in),
    .ext_stretch_n_in (ext_stretch_n_in),
    .auto_stall_off_in (auto_stall_off_r),
    .high_frame_stretch_in (high_frame_stretch_r),
    .acc (acc)
  );

  // =====================================================================
  // Core sequencing
  cbw_pkg::cbw_core_state_t core_r;
  logic req_r;
  logic open_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic write_r;
  logic [7:0] ip_hi_r;
  logic [7:0] ip_lo_r;
  logic ready_r;
  logic [7:0] rdata_r;

  wire booting = (core_r != cbw_pkg::CBW_RUN);
  wire can_launch = !open_r && !req_r;
  wire launch_boot = booting && can_launch;
  wire launch_cpu = (core_r == cbw_pkg::CBW_RUN) && can_launch && cpu_req_in;
  wire [15:0] boot_addr = (core_r == cbw_pkg::CBW_BOOT_HI) ? `CBW_VEC_HI_ADDR
    : `CBW_VEC_LO_ADDR;

  assign acc.req = req_r;
  assign acc.addr = addr_r;

  // Boot fetches the reset vector before any instruction access is accepted
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_r <= cbw_pkg::CBW_BOOT_HI;
    end else begin
      case (core_r)
        cbw_pkg::CBW_BOOT_HI: begin
          if (acc.fin) begin
            core_r <= cbw_pkg::CBW_BOOT_LO;
          end
        end
        cbw_pkg::CBW_BOOT_LO: begin
          if (acc.fin) begin
            core_r <= cbw_pkg::CBW_RUN;
          end
        end
        cbw_pkg::CBW_RUN: begin
          core_r <= cbw_pkg::CBW_RUN;
        end
        default: begin
          core_r <= cbw_pkg::CBW_BOOT_HI;
        end
      endcase
    end
  end

  // Launch one access at a time; the open flag holds the core stalled until it ends
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_r <= 1'b0;
      open_r <= 1'b0;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      write_r <= 1'b0;
    end else begin
      req_r <= launch_boot || launch_cpu;
      if (launch_boot) begin
        open_r <= 1'b1;
        addr_r <= boot_addr;
        write_r <= 1'b0;
      end else if (launch_cpu) begin
        open_r <= 1'b1;
        addr_r <= cpu_addr_in;
        wdata_r <= cpu_wdata_in;
        write_r <= cpu_write_in;
      end else if (acc.fin) begin
        open_r <= 1'b0;
      end
    end
  end

  // Read data is taken on the last access cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ready_r <= acc.fin && !booting;
      if (acc.fin && !write_r) begin
        rdata_r <= mem_rdata_in;
      end
    end
  end

  // =====================================================================
  // AHB-Lite slave: zero-wait, always OKAY; unmapped reads give zero
  logic dp_write_r;
  logic [7:0] dp_ofs_r;
  logic [31:0] hrdata_r;

  wire take = hsel_in && hready_in && htrans_in[1];
  wire [7:0] ofs = haddr_in[7:0];
  wire reg_wr_c0 = dp_write_r && (dp_ofs_r == `CBW_OFS_SYS_CONFIG_0);
  wire reg_wr_c1 = dp_write_r && (dp_ofs_r == `CBW_OFS_SYS_CONFIG_1);
  wire reg_wr_flag = dp_write_r && (dp_ofs_r == `CBW_OFS_FLAG_WORD);
  wire reg_wr_stk = dp_write_r && (dp_ofs_r == `CBW_OFS_STACK_POINTER);
  wire reg_wr_ip = dp_write_r && (dp_ofs_r == `CBW_OFS_INSTR_POINTER);

  // =====================================================================
  // Instruction pointer: vector load at boot, then load or step
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ip_hi_r <= 8'h00;
      ip_lo_r <= 8'h00;
    end else if (acc.fin && core_r == cbw_pkg::CBW_BOOT_HI) begin
      ip_hi_r <= mem_rdata_in;
    end else if (acc.fin && core_r == cbw_pkg::CBW_BOOT_LO) begin
      ip_lo_r <= mem_rdata_in;
    end else if (reg_wr_ip) begin
      {ip_hi_r, ip_lo_r} <= hwdata_in[15:0];
    end else if (ip_load_in && !booting) begin
      {ip_hi_r, ip_lo_r} <= ip_value_in;
    end else if (ip_step_in && !booting) begin
      {ip_hi_r, ip_lo_r} <= {ip_hi_r, ip_lo_r} + 16'h0001;
    end
  end

  // =====================================================================
  // AHB-Lite register storage and read selection
  logic [7:0] flag_word_r;
  logic [7:0] stack_pointer_r;
  logic [31:0] rd_mux;

  // Read selection from the address phase so hrdata comes from a flop
  always_comb begin
    case (ofs)
      `CBW_OFS_SYS_CONFIG_0: rd_mux = {31'h00000000, high_frame_stretch_r};
      `CBW_OFS_SYS_CONFIG_1: rd_mux = {31'h00000000, auto_stall_off_r};
      `CBW_OFS_FLAG_WORD: rd_mux = {24'h000000, flag_word_r & `CBW_FLAG_WORD_MASK};
      `CBW_OFS_STACK_POINTER: rd_mux = {24'h000000, stack_pointer_r};
      `CBW_OFS_INSTR_POINTER: rd_mux = {16'h0000, ip_hi_r, ip_lo_r};
      `CBW_OFS_CORE_STATUS: rd_mux = {29'h00000000, acc.busy, open_r, !booting};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Address phase latch; a read that lands on a same-cycle write shows the old value
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_write_r <= 1'b0;
      dp_ofs_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      dp_write_r <= take && hwrite_in;
      dp_ofs_r <= ofs;
      if (take && !hwrite_in) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Configuration bits steer the wait generator
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_frame_stretch_r <= `CBW_RST_CONFIG;
      auto_stall_off_r <= `CBW_RST_CONFIG;
    end else begin
      if (reg_wr_c0) begin
        high_frame_stretch_r <= hwdata_in[`CBW_BIT_HIGH_FRAME_STRETCH];
      end
      if (reg_wr_c1) begin
        auto_stall_off_r <= hwdata_in[`CBW_BIT_AUTO_STALL_OFF];
      end
    end
  end

  // =====================================================================
  // Flag word: the instruction result wins over a software write to C/N/Z/V
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_word_r <= `CBW_RST_FLAG_WORD;
    end else begin
      if (reg_wr_flag) begin
        flag_word_r <= hwdata_in[7:0] & `CBW_FLAG_WORD_MASK;
      end
      if (flag_update_in) begin
        flag_word_r[`CBW_BIT_CARRY:`CBW_BIT_OVERFLOW] <= alu_flags_in;
      end
    end
  end

  // Condition evaluation from the stored flags
  logic cond_now;
  wire f_c = flag_word_r[`CBW_BIT_CARRY];
  wire f_n = flag_word_r[`CBW_BIT_NEGATIVE];
  wire f_z = flag_word_r[`CBW_BIT_ZERO];
  wire f_v = flag_word_r[`CBW_BIT_OVERFLOW];
  always_comb begin
    case (cond_sel_in)
      3'h0: cond_now = 1'b1;
      3'h1: cond_now = f_c;
      3'h2: cond_now = !f_c;
      3'h3: cond_now = f_n;
      3'h4: cond_now = f_z;
      3'h5: cond_now = !f_z;
      3'h6: cond_now = f_v;
      default: cond_now = !f_n;
    endcase
  end

  // =====================================================================
  // Stack pointer: pre-increment push, post-decrement pop, page zero only
  logic [7:0] stk_addr_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_pointer_r <= `CBW_RST_STACK_POINTER;
      stk_addr_r <= 8'h00;
    end else if (reg_wr_stk) begin
      stack_pointer_r <= hwdata_in[7:0];
    end else if (stk_push_in) begin
      stack_pointer_r <= stack_pointer_r + 8'h01;
      stk_addr_r <= stack_pointer_r + 8'h01;
    end else if (stk_pop_in) begin
      stk_addr_r <= stack_pointer_r;
      stack_pointer_r <= stack_pointer_r - 8'h01;
    end
  end

  // =====================================================================
  // Registered outputs
  logic cond_r;
  logic irq1_r;
  logic irq2_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cond_r <= 1'b0;
      irq1_r <= 1'b0;
      irq2_r <= 1'b0;
    end else begin
      cond_r <= cond_now;
      irq1_r <= irq_level1_in && flag_word_r[`CBW_BIT_LEVEL1_IRQ_GATE];
      irq2_r <= irq_level2_in && flag_word_r[`CBW_BIT_LEVEL2_IRQ_GATE];
    end
  end

  assign hrdata_out = hrdata_r;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign cpu_ready_out = ready_r;
  assign cpu_rdata_out = rdata_r;
  assign cpu_stall_out = open_r;
  assign mem_addr_out = addr_r;
  assign mem_wdata_out = wdata_r;
  assign mem_write_out = write_r;
  assign mem_strobe_out = acc.busy;
  assign ram_sel_out = open_r && acc.is_ram;
  assign pf_sel_out = open_r && acc.is_pf;
  assign pf_onchip_out = open_r && acc.pf_onchip;
  assign pf_frame_out = addr_r[7:4];
  assign ext_sel_out = open_r && acc.is_ext;
  assign stk_addr_out = {8'h00, stk_addr_r};
  assign cond_true_out = cond_r;
  assign instr_pointer_out = {ip_hi_r, ip_lo_r};
  assign irq_level1_take_out = irq1_r;
  assign irq_level2_take_out = irq2_r;
endmodule

// file: dv/cbw_mem_model.sv
// Behavioural external memory that answers reads and can hold the extend line
`timescale 1ns/10ps
module cbw_mem_model (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_strobe_in,
  input wire logic ext_sel_in,
  input wire logic [3:0] hold_in,
  output logic [7:0] mem_rdata_out,
  output logic ext_stretch_n_out
);
  // =====================================================================
  // Read data
  logic [7:0] junk_r;
  logic [7:0] dat;
  logic [3:0] cnt_r;
  // Vector bytes hold a known start address; other bytes hash the address
  assign dat = (mem_addr_in == 16'h7FFE) ? 8'h6A :
    (mem_addr_in == 16'h7FFF) ? 8'h35 : (mem_addr_in[7:0] ^ 8'h5A);
  // Released bus toggles so a stale byte can never look valid
  assign mem_rdata_out = mem_strobe_in ? dat : junk_r;
  // =====================================================================
  // Extend line: low for the first hold_in strobe cycles, pulled up otherwise
  assign ext_stretch_n_out = !(mem_strobe_in && ext_sel_in && cnt_r < hold_in);
  // Strobe cycle counter and idle-bus scrambler
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 4'h0;
      junk_r <= 8'hA5;
    end else begin
      cnt_r <= mem_strobe_in ? cnt_r + 4'h1 : 4'h0;
      junk_r <= ~junk_r;
    end
  end
endmodule

// file: dv/cbw_core_props.sv
// Concurrent checks on the ports of the bus/core block
`timescale 1ns/10ps
module cbw_core_props (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cpu_ready_out,
  input wire logic mem_strobe_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic ram_sel_out,
  input wire logic pf_onchip_out,
  input wire logic [3:0] pf_frame_out,
  input wire logic ext_sel_out,
  input wire logic ext_stretch_n_in,
  input wire logic [15:0] stk_addr_out,
  input wire logic irq_level1_in,
  input wire logic irq_level2_in,
  input wire logic irq_level1_take_out,
  input wire logic irq_level2_take_out
);
  // =====================================================================
  // One clock domain for every property
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_frame; pf_onchip_out |-> pf_frame_out inside {[4'h1:4'h7]} && !ext_sel_out
    && !ram_sel_out; endproperty
  a_frame: assert property (p_frame) else $error("frame index off");
  property p_ram; ram_sel_out |-> mem_addr_out[15:8] == 8'h00; endproperty
  a_ram: assert property (p_ram) else $error("ram select off page");
  property p_onchip; pf_onchip_out |-> mem_addr_out[15:4] inside {[12'h101:12'h107]};
  endproperty
  a_onchip: assert property (p_onchip) else $error("onchip frame wrong");
  property p_stretch; mem_strobe_out && ext_sel_out && !ext_stretch_n_in |=> mem_strobe_out;
  endproperty
  a_stretch: assert property (p_stretch) else $error("extend ignored");
  property p_ready; cpu_ready_out |-> $past(mem_strobe_out) && !mem_strobe_out; endproperty
  a_ready: assert property (p_ready) else $error("ready not after strobe");
  property p_hold; mem_strobe_out && $past(mem_strobe_out) |-> $stable(mem_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("address moved in access");
  property p_stack; stk_addr_out[15:8] == 8'h00; endproperty
  a_stack: assert property (p_stack) else $error("stack left page zero");
  property p_gate1; irq_level1_take_out |-> $past(irq_level1_in); endproperty
  a_gate1: assert property (p_gate1) else $error("level1 taken unasked");
  property p_gate2; irq_level2_take_out |-> $past(irq_level2_in); endproperty
  a_gate2: assert property (p_gate2) else $error("level2 taken unasked");
endmodule
bind cbw_core cbw_core_props u_props (.*);

// file: dv/cbw_core_test.sv
// Self-checking bench for the bus/core block
`timescale 1ns/10ps
module cbw_core_test;
  // =====================================================================
  // Stimulus; the CPU write inputs stay constant
  logic sys_clk_in = 0, rst_in = 1, hsel_in = 0, hwrite_in = 0, cpu_req_in = 0;
  logic [31:0] haddr_in = 0, hwdata_in = 0;
  logic [1:0] htrans_in = 0;
  logic [2:0] hsize_in = 0, cond_sel_in = 0;
  logic [15:0] cpu_addr_in = 0;
  logic stk_push_in = 0, stk_pop_in = 0, flag_update_in = 0;
  logic irq_level1_in = 0, irq_level2_in = 0;
  logic [3:0] alu_flags_in = 0, hold = 0;
  logic cpu_write_in = 0, ip_load_in = 0, ip_step_in = 0;
  logic [7:0] cpu_wdata_in = 0;
  logic [15:0] ip_value_in = 0;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, cpu_ready_out, cpu_stall_out, mem_write_out, mem_strobe_out;
  wire [7:0] cpu_rdata_out, mem_wdata_out, mem_rdata_in;
  wire [15:0] mem_addr_out, stk_addr_out, instr_pointer_out;
  wire ram_sel_out, pf_sel_out, pf_onchip_out, ext_sel_out, ext_stretch_n_in;
  wire [3:0] pf_frame_out;
  wire cond_true_out, irq_level1_take_out, irq_level2_take_out;
  wire hready_in = hreadyout_out;
  int fail_count = 0, compares = 0;
  logic [31:0] r;
  cbw_core DUT (.*);
  cbw_mem_model u_mem (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .mem_addr_in(mem_addr_out),
    .mem_strobe_in(mem_strobe_out), .ext_sel_in(ext_sel_out), .hold_in(hold),
    .mem_rdata_out(mem_rdata_in), .ext_stretch_n_out(ext_stretch_n_in));
  // 200 MHz clock
  always #2.5 sys_clk_in = ~sys_clk_in;
  // =====================================================================
  // Reporting
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // =====================================================================
  // AHB-Lite master; waits are bounded and a lost answer ends the run
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (hready_in !== 1'b1 && n < 20);
    if (hready_in !== 1'b1) begin
      chk("hready", 0, 1);
      give_verdict;
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    hsel_in <= 1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'b10;
    hwrite_in <= w;
    hsize_in <= 3'b010;
    rdy;
    hsel_in <= 0;
    htrans_in <= 2'b00;
    hwdata_in <= d;
    rdy;
    r = hrdata_out;
  endtask
  // =====================================================================
  // Scenarios
  task t_regs;
    int n;
    for (n = 0; n < 40 && r[0] !== 1'b1; n++) ahb(0, 8'h14, 0);
    chk("boot_done", r[0], 1);
    ahb(0, 8'h08, 0); chk("flag_word", r, 0);
    ahb(0, 8'h0C, 0); chk("stack_pointer", r, 0);
    ahb(0, 8'h04, 0); chk("sys_config_1", r, 0);
    ahb(0, 8'h10, 0); chk("instr_pointer", r, 32'h6A35);
    chk("ip_port", instr_pointer_out, 32'h6A35);
    @(posedge sys_clk_in);
    ip_step_in <= 1;
    @(posedge sys_clk_in);
    ip_step_in <= 0;
    ip_load_in <= 1;
    ip_value_in <= 16'h1234;
    #1;
    chk("ip_step", instr_pointer_out, 32'h6A36);
    @(posedge sys_clk_in);
    ip_load_in <= 0;
    #1;
    chk("ip_load", instr_pointer_out, 32'h1234);
    chk("hresp", hresp_out, 0);
    ahb(0, 8'h40, 0); chk("unmapped", r, 0);
    $display("test regs done");
  endtask
  task t_flags;
    int i;
    ahb(1, 8'h08, 32'hFF); ahb(0, 8'h08, 0); chk("flag_rw", r, 32'hFC);
    irq_level1_in <= 1; irq_level2_in <= 1;
    ahb(1, 8'h08, 32'h04); repeat (2) @(posedge sys_clk_in); #1;
    chk("gates", {irq_level2_take_out, irq_level1_take_out}, 2'b01);
    ahb(1, 8'h08, 32'h08); repeat (2) @(posedge sys_clk_in); #1;
    chk("gates", {irq_level2_take_out, irq_level1_take_out}, 2'b10);
    ahb(1, 8'h08, 0);
    @(posedge sys_clk_in); flag_update_in <= 1; alu_flags_in <= 4'hA;
    @(posedge sys_clk_in); flag_update_in <= 0;
    ahb(0, 8'h08, 0); chk("flags", r, 32'hA0);
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk_in); cond_sel_in <= i[2:0];
      repeat (2) @(posedge sys_clk_in); #1;
      chk("cond", cond_true_out, (8'h93 >> i) & 1);
    end
    $display("test flags done");
  endtask
  // One CPU read with given config; counts strobe cycles until ready
  task acc(input logic [15:0] a, input logic c0, input logic c1, input logic [3:0] h,
      input int es, input logic [3:0] esel);
    int n, s;
    logic [3:0] sel;
    ahb(1, 8'h00, c0); ahb(1, 8'h04, c1); hold <= h;
    @(posedge sys_clk_in); cpu_req_in <= 1; cpu_addr_in <= a;
    @(posedge sys_clk_in); cpu_req_in <= 0;
    n = 0; s = 0; sel = 0;
    do begin
      @(posedge sys_clk_in); #1;
      if (mem_strobe_out === 1'b1) begin
        s++;
        sel = {ram_sel_out, pf_sel_out, pf_onchip_out, ext_sel_out};
        chk("stall_wr", {cpu_stall_out, mem_write_out}, 2'b10);
      end
      n++;
    end while (cpu_ready_out !== 1'b1 && n < 40);
    chk("strobe_len", s, es);
    chk("rdata", cpu_rdata_out, a[7:0] ^ 8'h5A);
    chk("select", sel, esel);
    chk("stall_end", cpu_stall_out, 0);
    if (n >= 40) begin
      chk("ready_timeout", 0, 1);
      give_verdict;
    end
  endtask
  task t_access;
    acc(16'h0020, 0, 0, 0, 1, 4'b1000);
    acc(16'h8000, 0, 0, 0, 2, 4'b0001);
    acc(16'h8000, 0, 1, 0, 1, 4'b0001);
    acc(16'h1010, 0, 0, 0, 1, 4'b0110);
    acc(16'h10C4, 1, 0, 0, 3, 4'b0101);
    acc(16'h10F0, 1, 1, 0, 3, 4'b0101);
    acc(16'h8001, 0, 0, 4, 5, 4'b0001);
    acc(16'h8002, 0, 1, 4, 5, 4'b0001);
    $display("test access done");
  endtask
  task pulse(input logic psh);
    @(posedge sys_clk_in); stk_push_in <= psh; stk_pop_in <= !psh;
    @(posedge sys_clk_in); stk_push_in <= 0; stk_pop_in <= 0; #1;
  endtask
  task t_stack;
    ahb(1, 8'h0C, 32'hFE);
    pulse(1); chk("push", stk_addr_out, 16'h00FF);
    pulse(1); chk("wrap", stk_addr_out, 16'h0000);
    pulse(0); chk("pop", stk_addr_out, 16'h0000);
    pulse(0); chk("pop_again", stk_addr_out, 16'h00FF);
    ahb(0, 8'h0C, 0); chk("stack_after", r, 32'hFE);
    $display("test stack done");
  endtask
  // =====================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 0;
    r = 0;
    t_regs;
    t_flags;
    t_access;
    t_stack;
    give_verdict;
  end
endmodule
